/* rtl/aps_params.svh */
/*
 * Constants for the alternate pin steering block: register offsets,
 * selection bit positions, implemented-bit masks and reset values.
 * Assumes inclusion by bare name from rtl/ sources.
 */
`ifndef APS_PARAMS_SVH
`define APS_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define APS_ADDR_W          4
`define APS_CTRL0_ADDR      4'h0
`define APS_CTRL1_ADDR      4'h1

// ----------------------------------------
// Selection bit positions
// ----------------------------------------
`define APS_RX_SEL_BIT      7
`define APS_T1G_SEL_BIT     3
`define APS_TX_SEL_BIT      2
`define APS_P1D_SEL_BIT     3
`define APS_P1C_SEL_BIT     2
`define APS_P2B_SEL_BIT     1
`define APS_CAPTURE_COMPARE_2_SEL_BIT    0

// ----------------------------------------
// Masks, reset values, idle levels
// ----------------------------------------
`define APS_CTRL0_MASK      8'h8c
`define APS_CTRL1_MASK      8'h0f
`define APS_CTRL_RESET      8'h00
`define APS_UNROUTED_LEVEL  1'b1
`define APS_NUM_PINS        10
`define APS_NUM_FUNCS       7

`endif

/* rtl/aps_pkg.sv */
/*
 * Types for the alternate pin steering block: pin and function codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package aps_pkg;

	// ----------------------------------------
	// Package pins reachable by steering
	// ----------------------------------------
	typedef enum logic [3:0] {
		PIN_A3   = 4'h0,
		PIN_A4   = 4'h1,
		PIN_A5   = 4'h2,
		PIN_B5   = 4'h3,
		PIN_B7   = 4'h4,
		PIN_C0   = 4'h5,
		PIN_C1   = 4'h6,
		PIN_C2   = 4'h7,
		PIN_C3   = 4'h8,
		PIN_C4   = 4'h9,
		PIN_NONE = 4'hf
	} aps_pin_t;

	// ----------------------------------------
	// Steered peripheral functions, low code wins a shared pin
	// ----------------------------------------
	typedef enum logic [2:0] {
		FN_RX   = 3'h0,
		FN_TX   = 3'h1,
		FN_T1G  = 3'h2,
		FN_P1D  = 3'h3,
		FN_P1C  = 3'h4,
		FN_P2B  = 3'h5,
		FN_CAPTURE_COMPARE_2 = 3'h6
	} aps_func_t;

endpackage

/* rtl/aps_steer_if.sv */
/*
 * Carrier for the two steering registers between the register file
 * and the pin router. Assumes both ends share one clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface aps_steer_if;
	logic [7:0] ctrl0;
	logic [7:0] ctrl1;

	modport regs (output ctrl0, output ctrl1);
	modport core (input ctrl0, input ctrl1);
endinterface

`default_nettype wire

/* rtl/aps_steer_regs.sv */
/*
 * Register file for the two steering registers on a plain strobe port.
 * Assumes one-cycle strobes, never both at once; read data one cycle late.
 */
`timescale 1ns/1ns
`default_nettype none
`include "aps_params.svh"

module aps_steer_regs
	import aps_pkg::*;
(
	input  wire logic                  clock_in,
	input  wire logic                  rst_in,
	input  wire logic [`APS_ADDR_W-1:0] reg_addr_in,
	input  wire logic [7:0]            reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic      [7:0]            reg_rdata_out,
	aps_steer_if.regs                  steer
);

	logic [7:0] ctrl0_ff;
	logic [7:0] ctrl1_ff;
	logic [7:0] rdata_ff;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ctrl0_ff <= `APS_CTRL_RESET;
			ctrl1_ff <= `APS_CTRL_RESET;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `APS_CTRL0_ADDR) begin
				ctrl0_ff <= reg_wdata_in & `APS_CTRL0_MASK;
			end
			if (reg_addr_in == `APS_CTRL1_ADDR) begin
				ctrl1_ff <= reg_wdata_in & `APS_CTRL1_MASK;
			end
		end
	end

	// ----------------------------------------
	// Read data, valid only in the cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd_in && reg_addr_in == `APS_CTRL0_ADDR) begin
			rdata_ff <= ctrl0_ff & `APS_CTRL0_MASK;
		end else if (reg_rd_in && reg_addr_in == `APS_CTRL1_ADDR) begin
			rdata_ff <= ctrl1_ff & `APS_CTRL1_MASK;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata_out = rdata_ff;
	assign steer.ctrl0   = ctrl0_ff;
	assign steer.ctrl1   = ctrl1_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	resv_read_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(reg_rd_in) |-> (reg_rdata_out & ~($past(reg_addr_in == `APS_CTRL0_ADDR) ?
			`APS_CTRL0_MASK : `APS_CTRL1_MASK)) == 8'h00
	) else $error("reserved bits read nonzero");

	reset_clear_a: assert property (
		@(posedge clock_in)
		rst_in |=> (ctrl0_ff == 8'h00 && ctrl1_ff == 8'h00)
	) else $error("steering bits not cleared by reset");

	wr_effect_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(reg_wr_in && reg_addr_in == `APS_CTRL1_ADDR) && !$past(rst_in)
		|-> ctrl1_ff == ($past(reg_wdata_in) & `APS_CTRL1_MASK)
	) else $error("write to second register not taken");

endmodule

`default_nettype wire

/* rtl/aps_pin_steer.sv */
/*
 * Alternate pin function steering: routes six peripheral functions to
 * one of two pins each and receive to B5 or nowhere, under two software registers.
 * Assumes pad inputs are asynchronous; port latch, direction and all
 * peripheral override signals come from logic on clock_in.
 */
// Function
// - Receive on port B pin 5; 1 invalid
// - Timer gate from A4, or A3 when set
// - Transmit on B7, or C4 when set
// - PWM1 D on C2, or C0 when set
// - PWM1 C on C3, or C1 when set
// - PWM2 B on C2, or A4 when set
// - Capture/compare 2 on C3, or A5
// - Steering never changes direction register contents
// - Overrides only on selected pin; other unaffected
// - Unimplemented bits read as zero
// - All selection bits clear on any reset
`timescale 1ns/1ns
`default_nettype none
`include "aps_params.svh"

module aps_pin_steer
	import aps_pkg::*;
(
	input  wire logic                     clock_in,
	input  wire logic                     rst_in,
	input  wire logic [`APS_ADDR_W-1:0]   reg_addr_in,
	input  wire logic [7:0]               reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic      [7:0]               reg_rdata_out,
	input  wire logic [`APS_NUM_PINS-1:0] port_lat_in,
	input  wire logic [`APS_NUM_PINS-1:0] port_pin_direction_register_in,
	input  wire logic [`APS_NUM_PINS-1:0] pad_in,
	output logic      [`APS_NUM_PINS-1:0] pad_out_out,
	output logic      [`APS_NUM_PINS-1:0] pad_oe_out,
	output logic      [`APS_NUM_PINS-1:0] pin_level_out,
	input  wire logic [`APS_NUM_FUNCS-1:0] func_val_ovr_in,
	input  wire logic [`APS_NUM_FUNCS-1:0] func_val_in,
	input  wire logic [`APS_NUM_FUNCS-1:0] func_dir_ovr_in,
	input  wire logic [`APS_NUM_FUNCS-1:0] func_dir_in,
	output logic      [`APS_NUM_FUNCS-1:0] func_level_out
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	aps_steer_if steer ();

	logic [`APS_NUM_PINS-1:0]  pad_meta_ff;
	logic [`APS_NUM_PINS-1:0]  pad_sync_ff;
	logic [`APS_NUM_PINS-1:0]  pad_out_ff;
	logic [`APS_NUM_PINS-1:0]  pad_oe_ff;
	logic [`APS_NUM_FUNCS-1:0] func_level_ff;
	logic [`APS_NUM_PINS-1:0]  nxt_pad_out;
	logic [`APS_NUM_PINS-1:0]  nxt_pad_oe;
	logic [`APS_NUM_FUNCS-1:0] nxt_func_level;
	logic [`APS_NUM_PINS-1:0]  val_owned;
	logic [`APS_NUM_PINS-1:0]  dir_owned;
	logic [`APS_NUM_PINS-1:0]  val_pick;
	logic [`APS_NUM_PINS-1:0]  dir_pick;
	logic                      rx_sel;
	logic                      t1g_sel;
	logic                      tx_sel;
	logic                      p1d_sel;
	logic                      p1c_sel;
	logic                      p2b_sel;
	logic                      capture_compare_2_sel;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	aps_steer_regs u_regs (
		.clock_in      (clock_in),
		.rst_in        (rst_in),
		.reg_addr_in   (reg_addr_in),
		.reg_wdata_in  (reg_wdata_in),
		.reg_wr_in     (reg_wr_in),
		.reg_rd_in     (reg_rd_in),
		.reg_rdata_out (reg_rdata_out),
		.steer         (steer.regs)
	);

	assign rx_sel   = steer.ctrl0[`APS_RX_SEL_BIT];
	assign t1g_sel  = steer.ctrl0[`APS_T1G_SEL_BIT];
	assign tx_sel   = steer.ctrl0[`APS_TX_SEL_BIT];
	assign p1d_sel  = steer.ctrl1[`APS_P1D_SEL_BIT];
	assign p1c_sel  = steer.ctrl1[`APS_P1C_SEL_BIT];
	assign p2b_sel  = steer.ctrl1[`APS_P2B_SEL_BIT];
	assign capture_compare_2_sel = steer.ctrl1[`APS_CAPTURE_COMPARE_2_SEL_BIT];

	// ----------------------------------------
	// Pin of each function under the current selection
	// ----------------------------------------
	function automatic aps_pin_t sel_pin(input logic [2:0] idx,
	                                     input logic [7:0] c0,
	                                     input logic [7:0] c1);
		aps_pin_t p;
		p = PIN_NONE;
		case (aps_func_t'(idx))
			FN_RX: begin
				p = c0[`APS_RX_SEL_BIT] ? PIN_NONE : PIN_B5;
			end
			FN_T1G: begin
				p = c0[`APS_T1G_SEL_BIT] ? PIN_A3 : PIN_A4;
			end
			FN_TX: begin
				p = c0[`APS_TX_SEL_BIT] ? PIN_C4 : PIN_B7;
			end
			FN_P1D: begin
				p = c1[`APS_P1D_SEL_BIT] ? PIN_C0 : PIN_C2;
			end
			FN_P1C: begin
				p = c1[`APS_P1C_SEL_BIT] ? PIN_C1 : PIN_C3;
			end
			FN_P2B: begin
				p = c1[`APS_P2B_SEL_BIT] ? PIN_A4 : PIN_C2;
			end
			FN_CAPTURE_COMPARE_2: begin
				p = c1[`APS_CAPTURE_COMPARE_2_SEL_BIT] ? PIN_A5 : PIN_C3;
			end
			default: begin
				p = PIN_NONE;
			end
		endcase
		return p;
	endfunction

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pad_meta_ff <= '0;
			pad_sync_ff <= '0;
		end else begin
			pad_meta_ff <= pad_in;
			pad_sync_ff <= pad_meta_ff;
		end
	end

	assign pin_level_out = pad_sync_ff;

	// ----------------------------------------
	// Output and direction routing per pin
	// ----------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < `APS_NUM_PINS; gp++) begin : g_pin
			always_comb begin
				val_owned[gp] = 1'b0;
				dir_owned[gp] = 1'b0;
				val_pick[gp]  = 1'b0;
				dir_pick[gp]  = 1'b0;
				for (int f = `APS_NUM_FUNCS - 1; f >= 0; f--) begin
					if (sel_pin(3'(f), steer.ctrl0, steer.ctrl1) == aps_pin_t'(4'(gp))) begin
						if (func_val_ovr_in[f]) begin
							val_owned[gp] = 1'b1;
							val_pick[gp]  = func_val_in[f];
						end
						if (func_dir_ovr_in[f]) begin
							dir_owned[gp] = 1'b1;
							dir_pick[gp]  = func_dir_in[f];
						end
					end
				end
				nxt_pad_out[gp] = val_owned[gp] ? val_pick[gp] : port_lat_in[gp];
				nxt_pad_oe[gp]  = dir_owned[gp] ? dir_pick[gp] : ~port_pin_direction_register_in[gp];
			end

			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					pad_out_ff[gp] <= 1'b0;
					pad_oe_ff[gp]  <= 1'b0;
				end else begin
					pad_out_ff[gp] <= nxt_pad_out[gp];
					pad_oe_ff[gp]  <= nxt_pad_oe[gp];
				end
			end
		end
	endgenerate

	assign pad_out_out = pad_out_ff;
	assign pad_oe_out  = pad_oe_ff;

	// ----------------------------------------
	// Input return to peripherals
	// ----------------------------------------
	always_comb begin
		aps_pin_t p;
		p = PIN_NONE;
		for (int f = 0; f < `APS_NUM_FUNCS; f++) begin
			p = sel_pin(3'(f), steer.ctrl0, steer.ctrl1);
			if (p == PIN_NONE) begin
				nxt_func_level[f] = `APS_UNROUTED_LEVEL;
			end else begin
				nxt_func_level[f] = pad_sync_ff[p];
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			func_level_ff <= {`APS_NUM_FUNCS{`APS_UNROUTED_LEVEL}};
		end else begin
			func_level_ff <= nxt_func_level;
		end
	end

	assign func_level_out = func_level_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	rx_route_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		!$past(rst_in) |-> func_level_out[FN_RX] ==
			($past(rx_sel) ? `APS_UNROUTED_LEVEL : $past(pad_sync_ff[PIN_B5]))
	) else $error("receive input not taken from its pin");

	t1g_route_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		!$past(rst_in) |-> func_level_out[FN_T1G] ==
			($past(t1g_sel) ? $past(pad_sync_ff[PIN_A3]) : $past(pad_sync_ff[PIN_A4]))
	) else $error("timer gate input on wrong pin");

	tx_route_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(func_val_ovr_in[FN_TX]) && !$past(rst_in) |->
			(tx_sel == $past(tx_sel)) ?
			($past(tx_sel) ? pad_out_out[PIN_C4] == $past(func_val_in[FN_TX])
			               : pad_out_out[PIN_B7] == $past(func_val_in[FN_TX])) : 1'b1
	) else $error("transmit output on wrong pin");

	p1d_route_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(func_val_ovr_in[FN_P1D]) && !$past(rst_in) |->
			($past(p1d_sel) ? pad_out_out[PIN_C0] : pad_out_out[PIN_C2])
			== $past(func_val_in[FN_P1D])
	) else $error("pwm1 d output on wrong pin");

	p1c_route_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(func_val_ovr_in[FN_P1C]) && !$past(rst_in) |->
			($past(p1c_sel) ? pad_out_out[PIN_C1] : pad_out_out[PIN_C3])
			== $past(func_val_in[FN_P1C])
	) else $error("pwm1 c output on wrong pin");

	p2b_route_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(func_val_ovr_in[FN_P2B] && p2b_sel && !(func_val_ovr_in[FN_T1G] && !t1g_sel))
		&& !$past(rst_in) |-> pad_out_out[PIN_A4] == $past(func_val_in[FN_P2B])
	) else $error("pwm2 b output missing from alternate pin");

	capture_compare_2_route_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(func_dir_ovr_in[FN_CAPTURE_COMPARE_2] && capture_compare_2_sel) && !$past(rst_in)
		|-> pad_oe_out[PIN_A5] == $past(func_dir_in[FN_CAPTURE_COMPARE_2])
	) else $error("capture compare direction not on alternate pin");

	dir_keep_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(reg_wr_in && !func_dir_ovr_in[FN_RX]) && !$past(rst_in)
		|-> pad_oe_out[PIN_B5] == !$past(port_pin_direction_register_in[PIN_B5])
	) else $error("register write disturbed pin direction");

	unsel_pin_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$past(tx_sel) && !$past(rst_in) |->
			pad_out_out[PIN_B7] == $past(port_lat_in[PIN_B7]) &&
			pad_oe_out[PIN_B7] == !$past(port_pin_direction_register_in[PIN_B7])
	) else $error("unselected pin lost port behaviour");

endmodule

`default_nettype wire

/* tb/aps_pad_model.sv */
/*
 * Pad side of the steering block: resolves each package pin from the
 * block's drive value and enable. Assumes weak pull-ups on every pin.
 */
`timescale 1ns/1ns
`default_nettype none
`include "aps_params.svh"

module aps_pad_model (
	input  wire logic [`APS_NUM_PINS-1:0] pad_drv_in,
	input  wire logic [`APS_NUM_PINS-1:0] pad_en_in,
	output logic      [`APS_NUM_PINS-1:0] pad_level_out
);
	// ----------------------------------------
	// Pin resolution
	// ----------------------------------------
	// Released pins float up through the pull-up
	always_comb begin
		for (int i = 0; i < `APS_NUM_PINS; i++) begin
			pad_level_out[i] = pad_en_in[i] ? pad_drv_in[i] : 1'b1;
		end
	end
endmodule

`default_nettype wire

/* tb/tb_aps_pin_steer.sv */
/*
 * Self-checking bench for the pin steering block: register access,
 * routing of every function under both selection settings, reset clearing.
 * Assumes the pad model stands between pad outputs and pad inputs.
 */
`timescale 1ns/1ns
`default_nettype none
`include "aps_params.svh"

module tb_aps_pin_steer;
	import aps_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                      clock_in = 1'b0;
	logic                      rst_in = 1'b1;
	logic [`APS_ADDR_W-1:0]    reg_addr_in = '0;
	logic [7:0]                reg_wdata_in = '0;
	logic                      reg_wr_in = 1'b0;
	logic                      reg_rd_in = 1'b0;
	logic [7:0]                reg_rdata_out;
	logic [`APS_NUM_PINS-1:0]  port_lat_in = '1;
	logic [`APS_NUM_PINS-1:0]  port_pin_direction_register_in = '1;
	logic [`APS_NUM_PINS-1:0]  pad_in;
	logic [`APS_NUM_PINS-1:0]  pad_out_out;
	logic [`APS_NUM_PINS-1:0]  pad_oe_out;
	logic [`APS_NUM_PINS-1:0]  pin_level_out;
	logic [`APS_NUM_FUNCS-1:0] func_val_ovr_in = '0;
	logic [`APS_NUM_FUNCS-1:0] func_val_in = '0;
	logic [`APS_NUM_FUNCS-1:0] func_dir_ovr_in = '0;
	logic [`APS_NUM_FUNCS-1:0] func_dir_in = '1;
	logic [`APS_NUM_FUNCS-1:0] func_level_out;
	int                        n_mismatch = 0;
	int                        checked = 0;
	logic [9:0]                exp;
	// Case table: function, register, written value, expected pin (f = none)
	int                        cs_fn [14] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6};
	logic [3:0]                cs_adr [14] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1};
	logic [7:0]                cs_dat [14] = '{8'h00, 8'h80, 8'h00, 8'h04, 8'h00, 8'h08,
		8'h00, 8'h08, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01};
	logic [3:0]                cs_pin [14] = '{4'h3, 4'hf, 4'h4, 4'h9, 4'h1, 4'h0,
		4'h7, 4'h5, 4'h8, 4'h6, 4'h7, 4'h1, 4'h8, 4'h2};

	always #5 clock_in = ~clock_in;

	aps_pin_steer uut (
		.clock_in        (clock_in),
		.rst_in          (rst_in),
		.reg_addr_in     (reg_addr_in),
		.reg_wdata_in    (reg_wdata_in),
		.reg_wr_in       (reg_wr_in),
		.reg_rd_in       (reg_rd_in),
		.reg_rdata_out   (reg_rdata_out),
		.port_lat_in     (port_lat_in),
		.port_pin_direction_register_in    (port_pin_direction_register_in),
		.pad_in          (pad_in),
		.pad_out_out     (pad_out_out),
		.pad_oe_out      (pad_oe_out),
		.pin_level_out   (pin_level_out),
		.func_val_ovr_in (func_val_ovr_in),
		.func_val_in     (func_val_in),
		.func_dir_ovr_in (func_dir_ovr_in),
		.func_dir_in     (func_dir_in),
		.func_level_out  (func_level_out)
	);

	aps_pad_model pads (
		.pad_drv_in    (pad_out_out),
		.pad_en_in     (pad_oe_out),
		.pad_level_out (pad_in)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [9:0] seen, input logic [9:0] want);
		checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask

	task automatic do_reset();
		rst_in <= 1'b1;
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
	endtask

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#50000;
		n_mismatch++;
		conclude();
	end

	initial begin
		logic [7:0] d;
		do_reset();
		rd(4'h0, d);
		check(10'(d), 10'h000);
		rd(4'h1, d);
		check(10'(d), 10'h000);
		$display("test reset values done");
		wr(4'h0, 8'hff);
		wr(4'h1, 8'hff);
		wr(4'h2, 8'h55);
		rd(4'h0, d);
		check(10'(d), 10'h08c);
		rd(4'h1, d);
		check(10'(d), 10'h00f);
		rd(4'h2, d);
		check(10'(d), 10'h000);
		$display("test register access done");
		for (int i = 0; i < 14; i++) begin
			@(posedge clock_in);
			func_val_ovr_in <= 7'(1) << cs_fn[i];
			func_dir_ovr_in <= 7'(1) << cs_fn[i];
			wr(cs_adr[i], cs_dat[i]);
			@(posedge clock_in);
			#1;
			exp = (cs_pin[i] == 4'hf) ? 10'h000 : 10'(1) << cs_pin[i];
			check(pad_oe_out, exp);
			check(pad_out_out, ~exp);
			repeat (3) @(posedge clock_in);
			#1;
			check(10'(func_level_out[cs_fn[i]]), 10'(exp == 10'h000));
			check(pin_level_out, ~exp);
		end
		$display("test routing table done");
		@(posedge clock_in);
		func_val_ovr_in <= 7'h02;
		func_dir_ovr_in <= 7'h02;
		port_lat_in <= 10'h2f0;
		port_pin_direction_register_in <= 10'h2cc;
		wr(4'h0, 8'h04);
		@(posedge clock_in);
		#1;
		check(pad_out_out, 10'h0f0);
		check(pad_oe_out, 10'h333);
		$display("test port behaviour done");
		wr(4'h1, 8'h0f);
		do_reset();
		rd(4'h0, d);
		check(10'(d), 10'h000);
		rd(4'h1, d);
		check(10'(d), 10'h000);
		$display("test second reset done");
		conclude();
	end
endmodule

`default_nettype wire
